// ---- tpos_pkg.sv ----
// constants, types and helpers shared by the trace port output stage
package tpos_pkg;

  // datapath and setting widths
  localparam int unsigned DIV_W = 13;
  localparam int unsigned PORT_W = 16;
  localparam int unsigned BYTE_W = 8;
  localparam int unsigned WID_W = 5;
  localparam int unsigned BUF_W = 24;
  localparam int unsigned FIFO_DEPTH = 16;
  localparam int unsigned CFG_W = 2 + DIV_W + WID_W;

  // output protocol select encodings
  localparam logic [1:0] MODE_PAR = 2'h0;
  localparam logic [1:0] MODE_MAN = 2'h1;
  localparam logic [1:0] MODE_NRZ = 2'h2;

  // reset values of the settings
  localparam logic [1:0] MODE_RST = MODE_MAN;
  localparam logic [DIV_W-1:0] DIV_RST = 13'h0000;
  localparam logic [WID_W-1:0] WID_RST = 5'h01;
  localparam logic [CFG_W-1:0] CFG_RST = {MODE_RST, DIV_RST, WID_RST};

  // width bitmap: bit n-1 set means width n is built in
  localparam logic [PORT_W-1:0] WIDTH_SUPPORTED = 16'h888b;

  // revision field value, arbitrary
  localparam logic [3:0] REVISION_DEFAULT = 4'h5;

  // serial framing figures
  localparam logic [3:0] MAN_MAX_BYTES = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic NRZ_IDLE = 1'h1;
  localparam logic MAN_IDLE = 1'h0;
  localparam logic NRZ_START = 1'h0;
  localparam logic MAN_START_HI = 1'h1;

  // parallel buffer: highest fill that still takes another byte
  localparam logic [WID_W-1:0] BUF_ROOM = 5'h10;
  localparam logic [WID_W-1:0] BYTE_BITS = 5'h08;

  // serial engine states, gray along idle-start-data-stop
  typedef enum logic [1:0] {
    ST_IDLE = 2'h0,
    ST_START = 2'h1,
    ST_DATA = 2'h3,
    ST_STOP = 2'h2
  } tpos_state_e;

  // one-hot current width to a bit count; unsupported picks one bit
  function automatic logic [WID_W-1:0] width_of(input logic [PORT_W-1:0] sel);
    logic [PORT_W-1:0] ok;
    ok = sel & WIDTH_SUPPORTED;
    if (ok[15]) return 5'h10;
    else if (ok[11]) return 5'h0c;
    else if (ok[7]) return 5'h08;
    else if (ok[3]) return 5'h04;
    else if (ok[1]) return 5'h02;
    else return 5'h01;
  endfunction : width_of

endpackage : tpos_pkg

// ---- tpos_sync.sv ----
// two flip-flop level synchroniser
`timescale 1ns/1ps
module tpos_sync (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic d,
  output logic q
);
  logic meta_q; // first stage, read only by q

  // plain two-stage chain, nothing taps the first stage
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      meta_q <= 1'h0;
      q <= 1'h0;
    end else begin
      meta_q <= d;
      q <= meta_q;
    end
  end
endmodule : tpos_sync

// ---- tpos_fifo.sv ----
// byte fifo with valid/ready on both sides
`timescale 1ns/1ps
module tpos_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int unsigned AW = $clog2(DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH]; // storage words
  logic [AW-1:0] wr_q; // write pointer, wraps naturally
  logic [AW-1:0] rd_q; // read pointer
  logic [AW:0] cnt_q; // fill level
  logic push;
  logic pop;

  // honest flags: full stalls the source, empty hides data
  assign in_ready = (cnt_q != FULL);
  assign out_valid = (cnt_q != '0);
  assign out_data = mem_q[rd_q];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // storage write, no reset needed on the array
  always_ff @(posedge clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end

  // pointers and level
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= push ? wr_q + 1'h1 : wr_q;
      rd_q <= pop ? rd_q + 1'h1 : rd_q;
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  fifo_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
    (cnt_q == FULL && in_valid) |=> (cnt_q <= FULL))
    else $error("fifo level ran past depth");
endmodule : tpos_fifo

// ---- tpos_output_stage.sv ----
// trace port output stage: parallel, nrz serial and manchester serial
`timescale 1ns/1ps
module tpos_output_stage
  import tpos_pkg::*;
#(
  parameter logic [3:0] REVISION_ID = REVISION_DEFAULT // arbitrary value
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic trace_ref_clk,
  input wire logic trace_rst_n,
  input wire logic [BYTE_W-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [1:0] output_protocol_select,
  input wire logic [DIV_W-1:0] prescale_divisor,
  input wire logic [PORT_W-1:0] current_width_reg,
  output logic [PORT_W-1:0] supported_width_reg,
  output logic [3:0] revision_field,
  output logic trace_clk_out,
  output logic [PORT_W-1:0] trace_data,
  output logic serial_out
);

  // ---------------- bus clock domain ----------------

  logic fifo_valid; // fifo holds a byte
  logic [BYTE_W-1:0] fifo_data; // fifo head
  logic fifo_ready; // drain side ready
  logic req_q; // toggles once per transfer
  logic ack_s; // returned toggle, synchronised
  logic busy; // transfer outstanding
  logic cfg_dirty; // settings differ from last sent
  logic launch; // start a transfer this cycle
  logic [CFG_W-1:0] cfg_now; // settings packed as seen now
  logic [CFG_W-1:0] sent_cfg_q; // settings last sent
  logic [CFG_W-1:0] x_cfg_q; // settings held for the crossing
  logic [BYTE_W-1:0] x_data_q; // byte held for the crossing
  logic x_has_q; // the transfer carries a byte

  // fixed identity and capability outputs
  assign supported_width_reg = WIDTH_SUPPORTED;
  assign revision_field = REVISION_ID;

  // fifo in front of the crossing; back-pressure reaches in_ready
  tpos_fifo #(
    .WIDTH(BYTE_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk(core_clk),
    .rst_n(rst_n),
    .in_valid(in_valid),
    .in_ready(in_ready),
    .in_data(in_data),
    .out_valid(fifo_valid),
    .out_ready(fifo_ready),
    .out_data(fifo_data)
  );

  // settings travel packed with each transfer
  assign cfg_now = {output_protocol_select, prescale_divisor,
                    width_of(current_width_reg)};
  assign busy = req_q ^ ack_s;
  assign cfg_dirty = (cfg_now != sent_cfg_q);
  assign fifo_ready = !busy;
  assign launch = !busy && (fifo_valid || cfg_dirty);

  // toggle handshake sender; held words stay still until ack returns
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      req_q <= 1'h0;
      x_data_q <= '0;
      x_has_q <= 1'h0;
      x_cfg_q <= CFG_RST;
      sent_cfg_q <= CFG_RST;
    end else if (launch) begin
      req_q <= !req_q;
      x_data_q <= fifo_data;
      x_has_q <= fifo_valid;
      x_cfg_q <= cfg_now;
      sent_cfg_q <= cfg_now;
    end
  end

  // ---------------- trace reference clock domain ----------------

  logic req_s; // request toggle, synchronised
  logic ack_q; // last request taken, also the ack toggle
  logic new_x; // a new transfer waits
  logic hold_full_q; // holding stage occupied
  logic hold_has_q; // holding stage carries a byte
  logic [BYTE_W-1:0] hold_data_q; // held byte
  logic [CFG_W-1:0] hold_cfg_q; // settings that came with it
  logic [CFG_W-1:0] act_cfg_q; // settings in force
  logic [1:0] act_mode;
  logic [DIV_W-1:0] act_div;
  logic [WID_W-1:0] act_w;
  logic [DIV_W-1:0] pre_cnt_q; // prescaler count
  logic tick; // one symbol period elapsed
  logic par;
  logic man;
  logic nrz;
  logic same; // held settings equal active ones
  logic eng_idle; // no frame or buffered bits in flight
  logic apply; // adopt new settings now
  logic drop; // settings-only transfer, or a byte while no protocol is on
  logic avail; // a byte is ready for the engines
  logic consume; // holding stage empties

  // two flip-flop crossings for the toggles
  tpos_sync u_req_sync (
    .clk(trace_ref_clk),
    .rst_n(trace_rst_n),
    .d(req_q),
    .q(req_s)
  );
  tpos_sync u_ack_sync (
    .clk(core_clk),
    .rst_n(rst_n),
    .d(ack_q),
    .q(ack_s)
  );

  assign act_mode = act_cfg_q[CFG_W-1 -: 2];
  assign act_div = act_cfg_q[WID_W +: DIV_W];
  assign act_w = act_cfg_q[WID_W-1:0];
  assign par = (act_mode == MODE_PAR);
  assign man = (act_mode == MODE_MAN);
  assign nrz = (act_mode == MODE_NRZ);
  assign new_x = req_s ^ ack_q;
  assign same = (hold_cfg_q == act_cfg_q);

  // settings only switch between frames so no frame is torn
  assign apply = hold_full_q && !same && eng_idle;
  assign drop = hold_full_q && same && (!hold_has_q || !(par || man || nrz));
  assign avail = hold_full_q && same && hold_has_q;

  // prescaler: a tick every divisor+1 reference cycles
  assign tick = (pre_cnt_q == act_div);

  always_ff @(posedge trace_ref_clk) begin
    if (!trace_rst_n || apply) begin
      pre_cnt_q <= '0;
    end else begin
      pre_cnt_q <= tick ? '0 : pre_cnt_q + 1'h1;
    end
  end

  // parallel path signals
  logic [BUF_W-1:0] buf_q; // bits waiting, lsb goes out first
  logic [WID_W-1:0] bits_q; // count of valid bits in buf_q
  logic par_ok; // enough bits for a full word
  logic par_shift;
  logic par_flush; // pad a short tail so settings can move on
  logic par_take;
  logic [WID_W-1:0] bits_sh;
  logic [BUF_W-1:0] buf_sh;
  logic [WID_W-1:0] bits_d;
  logic [BUF_W-1:0] buf_d;
  logic [PORT_W-1:0] wmask; // active lanes
  logic tclk_q;
  logic [PORT_W-1:0] tdata_q;

  // serial path signals
  tpos_state_e st_q;
  logic h_q; // first half of a manchester pair sent
  logic [2:0] bit_q; // data bit index
  logic [BYTE_W-1:0] shreg_q; // byte being sent
  logic [3:0] blk_q; // bytes in this manchester block
  logic so_q;
  logic man_cont; // chain another byte into the block
  logic ser_take;
  logic idle_lvl;

  assign eng_idle = (st_q == ST_IDLE) && (bits_q == '0);
  assign wmask = PORT_W'((17'h1 << act_w) - 17'h1);

  // word out when the buffer can fill the active width
  assign par_ok = (bits_q >= act_w);
  assign par_shift = par && tick && par_ok;
  assign par_flush = par && tick && !par_ok && (bits_q != '0) && !avail;
  assign bits_sh = par_flush ? '0 : (par_shift ? bits_q - act_w : bits_q);
  assign buf_sh = par_flush ? '0 : (par_shift ? buf_q >> act_w : buf_q);
  assign par_take = par && avail && (bits_sh <= BUF_ROOM);
  assign bits_d = par_take ? bits_sh + BYTE_BITS : bits_sh;
  assign buf_d = par_take ? (buf_sh | (BUF_W'(hold_data_q) << bits_sh)) : buf_sh;

  // serial byte intake at idle, or chained inside a manchester block
  assign man_cont = man && (st_q == ST_DATA) && h_q && (bit_q == LAST_BIT)
                    && (blk_q < MAN_MAX_BYTES);
  assign ser_take = avail && tick && (man || nrz)
                    && ((st_q == ST_IDLE) || man_cont);
  assign idle_lvl = nrz ? NRZ_IDLE : MAN_IDLE;
  assign consume = drop || par_take || ser_take || (apply && !hold_has_q);

  // receiving end of the handshake; ack returns once the word is held
  always_ff @(posedge trace_ref_clk) begin
    if (!trace_rst_n) begin
      ack_q <= 1'h0;
      hold_full_q <= 1'h0;
      hold_has_q <= 1'h0;
      hold_data_q <= '0;
      hold_cfg_q <= CFG_RST;
    end else if (new_x && (!hold_full_q || consume)) begin
      ack_q <= req_s;
      hold_full_q <= 1'h1;
      hold_has_q <= x_has_q;
      hold_data_q <= x_data_q;
      hold_cfg_q <= x_cfg_q;
    end else if (consume) begin
      hold_full_q <= 1'h0;
    end
  end

  // active settings
  always_ff @(posedge trace_ref_clk) begin
    if (!trace_rst_n) begin
      act_cfg_q <= CFG_RST;
    end else if (apply) begin
      act_cfg_q <= hold_cfg_q;
    end
  end

  // parallel buffer
  always_ff @(posedge trace_ref_clk) begin
    if (!trace_rst_n) begin
      buf_q <= '0;
      bits_q <= '0;
    end else begin
      buf_q <= buf_d;
      bits_q <= bits_d;
    end
  end

  // clock and data share one edge, so there is no skew between them
  always_ff @(posedge trace_ref_clk) begin
    if (!trace_rst_n) begin
      tclk_q <= 1'h0;
      tdata_q <= '0;
    end else if (!par) begin
      tclk_q <= 1'h0;
      tdata_q <= '0;
    end else if (tick) begin
      tclk_q <= !tclk_q;
      // idle symbols go out as zero so a stale word is never sampled twice
      tdata_q <= (par_shift || par_flush) ? (buf_q[PORT_W-1:0] & wmask)
                                          : '0;
    end
  end

  // serial engine: each tick emits one symbol
  always_ff @(posedge trace_ref_clk) begin
    if (!trace_rst_n) begin
      st_q <= ST_IDLE;
      h_q <= 1'h0;
      bit_q <= '0;
      shreg_q <= '0;
      blk_q <= '0;
      so_q <= MAN_IDLE;
    end else if (tick) begin
      case (st_q)
        ST_IDLE: begin
          if (ser_take) begin
            shreg_q <= hold_data_q;
            bit_q <= '0;
            blk_q <= 4'h1;
            // nrz start is one low symbol, manchester start a high-low pair
            so_q <= man ? MAN_START_HI : NRZ_START;
            h_q <= man;
            st_q <= man ? ST_START : ST_DATA;
          end else begin
            so_q <= idle_lvl;
          end
        end
        ST_START: begin
          so_q <= !MAN_START_HI;
          h_q <= 1'h0;
          st_q <= ST_DATA;
        end
        ST_DATA: begin
          if (man && !h_q) begin
            so_q <= shreg_q[bit_q];
            h_q <= 1'h1;
          end else begin
            // second manchester half is the inverse of the first
            so_q <= man ? !shreg_q[bit_q] : shreg_q[bit_q];
            h_q <= 1'h0;
            if (bit_q != LAST_BIT) begin
              bit_q <= bit_q + 1'h1;
            end else if (ser_take) begin
              shreg_q <= hold_data_q;
              bit_q <= '0;
              blk_q <= blk_q + 1'h1;
            end else begin
              st_q <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          // nrz stop is one high symbol; manchester stop is two low ones
          so_q <= nrz ? NRZ_IDLE : MAN_IDLE;
          h_q <= man && !h_q;
          if (nrz || h_q) begin
            st_q <= ST_IDLE;
          end
        end
        default: begin
          st_q <= ST_IDLE;
        end
      endcase
    end
  end

  assign trace_clk_out = tclk_q;
  assign trace_data = tdata_q;
  assign serial_out = so_q;

  // helper: cycles since the last tick, to check symbol spacing
  logic [DIV_W-1:0] gap_q;
  logic gap_ok_q;

  always_ff @(posedge trace_ref_clk) begin
    if (!trace_rst_n || apply) begin
      gap_q <= '0;
      gap_ok_q <= 1'h0;
    end else if (tick) begin
      gap_q <= '0;
      gap_ok_q <= 1'h1;
    end else begin
      gap_q <= gap_q + 1'h1;
    end
  end

  sequence nrz_start_s;
    nrz && ser_take && (st_q == ST_IDLE);
  endsequence
  sequence nrz_first_s;
    !serial_out && (st_q == ST_DATA) && (bit_q == 3'h0);
  endsequence

  tick_spacing_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    (tick && gap_ok_q) |-> (gap_q == act_div))
    else $error("symbol tick spacing differs from divisor");
  clk_toggle_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    (par && tick) |=> (trace_clk_out != $past(trace_clk_out)))
    else $error("trace clock missed a symbol toggle");
  clk_static_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    !par |=> !trace_clk_out)
    else $error("trace clock moved in serial mode");
  data_hold_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    (par && !tick) |=> $stable(trace_data))
    else $error("parallel data changed inside a symbol");
  clk_data_align_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    ($past(par) && $changed(trace_data)) |-> $changed(trace_clk_out))
    else $error("data moved without a clock edge");
  nrz_frame_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    nrz_start_s |=> nrz_first_s)
    else $error("nrz start symbol missing");
  man_half_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    (man && tick && (st_q == ST_DATA) && h_q) |=> (serial_out != $past(serial_out)))
    else $error("manchester halves not inverse");
  man_start_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    (man && tick && (st_q == ST_START)) |=> (!serial_out && (st_q == ST_DATA)))
    else $error("manchester start pair broken");
  lsb_first_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    (tick && (st_q == ST_DATA) && (bit_q == 3'h0) && !h_q)
    |=> (serial_out == $past(shreg_q[0])))
    else $error("first data bit is not the lsb");
  cfg_switch_a: assert property (
    @(posedge trace_ref_clk) disable iff (!trace_rst_n)
    $changed(act_cfg_q) |-> $past(eng_idle))
    else $error("settings changed mid frame");
  xfer_busy_a: assert property (
    @(posedge core_clk) disable iff (!rst_n)
    launch |=> busy [*2])
    else $error("transfer finished too soon");

endmodule : tpos_output_stage

// ---- tpos_cap.sv ----
// analyzer model that captures and decodes the trace pins
`timescale 1ns/1ps
module tpos_cap (
  input wire logic ref_clk,
  input wire logic [1:0] mode,
  input wire logic [12:0] div,
  input wire logic trace_clk_out,
  input wire logic [15:0] trace_data,
  input wire logic serial_out
);
  logic [7:0] ser_q[$]; // decoded serial bytes
  logic [15:0] par_q[$]; // nonzero parallel words
  int gap; // ref cycles between trace clock edges
  int n_cyc;
  int n_skew; // data moved with no clock edge
  int n_frame_err; // bad start, bad stop, half-bit or block size
  int sl; // ref cycles per symbol
  int k;
  logic clk_p;
  logic ser_p;
  logic h;
  logic [7:0] b;
  logic [15:0] dat_p;
  assign sl = int'(div) + 1;

  // sample on both edges, once the edge has settled
  always @(trace_clk_out) begin
    #1;
    if (mode == 2'h0 && trace_data != 16'h0000) par_q.push_back(trace_data);
  end

  // edge spacing and skew watch
  always @(posedge ref_clk) begin
    n_cyc <= (trace_clk_out != clk_p) ? 1 : n_cyc + 1;
    if (trace_clk_out != clk_p) gap <= n_cyc;
    if (trace_data != dat_p && trace_clk_out == clk_p) n_skew <= n_skew + 1;
    clk_p <= trace_clk_out;
    dat_p <= trace_data;
  end

  task automatic wait_sym(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_sym

  // serial decoder; samples mid-symbol after the start edge
  initial forever begin
    @(posedge ref_clk);
    if (mode == 2'h2 && ser_p === 1'b1 && serial_out === 1'b0) begin
      wait_sym(sl / 2);
      for (k = 0; k < 8; k++) begin // lsb first
        wait_sym(sl);
        b[k] = serial_out;
      end
      wait_sym(sl);
      if (serial_out !== 1'b1) n_frame_err++;
      ser_q.push_back(b);
    end else if (mode == 2'h1 && ser_p === 1'b0 && serial_out === 1'b1) begin
      wait_sym(sl / 2 + sl);
      if (serial_out !== 1'b0) n_frame_err++;
      k = 0;
      forever begin
        wait_sym(sl);
        h = serial_out;
        wait_sym(sl);
        if (h === 1'b0 && serial_out === 1'b0) break; // stop pair
        if (serial_out !== ~h) n_frame_err++;
        b[k % 8] = h;
        k++;
        if (k % 8 == 0) ser_q.push_back(b);
      end
      if (k < 8 || k > 64 || k % 8 != 0) n_frame_err++;
    end
    ser_p = serial_out;
  end
endmodule : tpos_cap

// ---- tpos_output_stage_tb.sv ----
// self-checking bench for the trace port output stage
`timescale 1ns/1ps
module tpos_output_stage_tb;
  import tpos_pkg::*;
  // one case: settings, byte, first word expected
  typedef struct packed {
    logic [1:0] mode;
    logic [12:0] div;
    logic [15:0] sel;
    logic [7:0] byt;
    logic [15:0] exp;
  } tpos_row_s;
  logic core_clk = 1'b0;
  logic trace_ref_clk = 1'b0;
  logic rst_n = 1'b0;
  logic trace_rst_n = 1'b0;
  logic [7:0] in_data = 8'h00;
  logic in_valid = 1'b0;
  logic in_ready;
  logic [1:0] output_protocol_select = 2'h1;
  logic [12:0] prescale_divisor = 13'h0000;
  logic [15:0] current_width_reg = 16'h0001;
  logic [15:0] supported_width_reg;
  logic [3:0] revision_field;
  logic trace_clk_out;
  logic [15:0] trace_data;
  logic serial_out;
  int n_mismatch = 0;
  int n_compared = 0;
  int n_tog = 0; // trace clock edges since setup
  int skew0;
  logic full_seen = 1'b0; // fifo refused once
  // widths 16,12,8,4,2 and an unsupported pick
  tpos_row_s rows [10] = '{
    '{2'h2, 13'h3, 16'h0001, 8'ha5, 16'h00a5},
    '{2'h2, 13'h0, 16'h0001, 8'h3c, 16'h003c},
    '{2'h1, 13'h1, 16'h0001, 8'h96, 16'h0096},
    '{2'h1, 13'h4, 16'h0001, 8'h0f, 16'h000f},
    '{2'h0, 13'h2, 16'h0080, 8'h5a, 16'h005a},
    '{2'h0, 13'h0, 16'h8000, 8'h81, 16'h0081},
    '{2'h0, 13'h1, 16'h0008, 8'hc3, 16'h0003},
    '{2'h0, 13'h3, 16'h0004, 8'h81, 16'h0001},
    '{2'h0, 13'h1, 16'h0800, 8'h7e, 16'h007e},
    '{2'h0, 13'h2, 16'h0002, 8'h0e, 16'h0002}};

  always #5 core_clk = ~core_clk;
  always #7 trace_ref_clk = ~trace_ref_clk; // unrelated phase
  always @(trace_clk_out) n_tog++;
  always @(posedge core_clk) if (rst_n && in_valid && in_ready === 1'b0) full_seen <= 1'b1;

  tpos_output_stage tpos_output_stage_inst (
    .core_clk, .rst_n, .trace_ref_clk, .trace_rst_n, .in_data, .in_valid, .in_ready,
    .output_protocol_select, .prescale_divisor, .current_width_reg, .supported_width_reg,
    .revision_field, .trace_clk_out, .trace_data, .serial_out);

  tpos_cap tpos_cap_inst (
    .ref_clk(trace_ref_clk), .mode(output_protocol_select), .div(prescale_divisor),
    .trace_clk_out, .trace_data, .serial_out);

  task automatic conclude();
    if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : conclude

  task automatic check(input string what, input logic [15:0] e, input logic [15:0] g);
    n_compared++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", what, e, g);
      n_mismatch++;
    end
  endtask : check

  // settings are levels; give them time to cross and apply
  task automatic setup(input logic [1:0] m, input logic [12:0] d, input logic [15:0] s);
    @(negedge core_clk);
    output_protocol_select = m;
    prescale_divisor = d;
    current_width_reg = s;
    repeat (60) @(posedge core_clk);
    tpos_cap_inst.ser_q.delete();
    tpos_cap_inst.par_q.delete();
    skew0 = tpos_cap_inst.n_skew;
    n_tog = 0;
  endtask : setup

  // offer a byte and hold it until taken; valid stays up
  task automatic send(input logic [7:0] v);
    int t;
    @(negedge core_clk);
    in_data = v;
    in_valid = 1'b1;
    for (t = 0; t < 5000; t++) begin
      @(posedge core_clk);
      if (in_ready === 1'b1) return;
    end
    check("accept", 16'h1, 16'h0);
    conclude();
  endtask : send

  task automatic wait_out(input int n);
    @(negedge core_clk);
    in_valid = 1'b0;
    for (int t = 0; t < 60000; t++) begin
      @(posedge core_clk);
      if (tpos_cap_inst.ser_q.size() + tpos_cap_inst.par_q.size() >= n) return;
    end
    check("timeout", 16'h1, 16'h0);
    conclude();
  endtask : wait_out

  initial begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk);
    rst_n = 1'b1;
    trace_rst_n = 1'b1;
    foreach (rows[i]) begin
      setup(rows[i].mode, rows[i].div, rows[i].sel);
      send(rows[i].byt);
      wait_out(1);
      if (rows[i].mode == MODE_PAR) begin
        check("word", rows[i].exp, tpos_cap_inst.par_q[0]);
        check("gap", 16'(rows[i].div) + 16'h1, 16'(tpos_cap_inst.gap));
        check("skew", 16'(skew0), 16'(tpos_cap_inst.n_skew));
      end else begin
        check("byte", rows[i].exp, {8'h00, tpos_cap_inst.ser_q[0]});
        check("clock", 16'h0, 16'(n_tog));
      end
    end
    // second reset while the parallel port runs
    @(negedge core_clk);
    rst_n = 1'b0;
    trace_rst_n = 1'b0;
    repeat (4) @(posedge core_clk);
    #1;
    check("rst", 16'h0, trace_data | {14'h0, trace_clk_out, serial_out});
    @(negedge core_clk);
    rst_n = 1'b1;
    trace_rst_n = 1'b1;
    check("sizes", 16'h888b, supported_width_reg);
    check("rev", {12'h0, REVISION_DEFAULT}, {12'h0, revision_field});
    // no protocol selected: a byte is swallowed, pins stay quiet, settings still move
    setup(2'h3, 13'h0000, 16'h0001);
    send(8'h55);
    wait_out(0);
    repeat (100) @(posedge core_clk);
    #1;
    check("quiet", 16'h0, 16'(n_tog + tpos_cap_inst.ser_q.size() + tpos_cap_inst.par_q.size()));
    check("idle", 16'h0, {15'h0, serial_out});
    // slow nrz drain so the fifo fills and refuses
    setup(MODE_NRZ, 13'h0014, 16'h0001);
    for (int i = 0; i < 24; i++) send(8'h30 + 8'(i));
    wait_out(24);
    check("full", 16'h1, {15'h0, full_seen});
    foreach (tpos_cap_inst.ser_q[i]) check("order", 16'h30 + 16'(i), {8'h00, tpos_cap_inst.ser_q[i]});
    // back-to-back manchester bytes chain into one block
    setup(MODE_MAN, 13'h0001, 16'h0001);
    for (int i = 0; i < 3; i++) send(8'hc0 + 8'(i));
    wait_out(3);
    foreach (tpos_cap_inst.ser_q[i]) check("chain", 16'hc0 + 16'(i), {8'h00, tpos_cap_inst.ser_q[i]});
    repeat (20) @(posedge core_clk);
    check("frame", 16'h0, 16'(tpos_cap_inst.n_frame_err));
    conclude();
  end
endmodule : tpos_output_stage_tb
